// ==== verilog/lbe_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// Brightness equaliser sequencer. The converter is outside: this block drives
// its controls and receives its end flag and result.
module lbe_top #(
   parameter int unsigned SUPPLY_WAIT = lbe_pkg::SUPPLY_WAIT_CYCLES,
   parameter logic [15:0] PWM_PERIOD = lbe_pkg::PERIOD_RESET
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic adc_end,
   input wire logic [9:0] adc_result,
   output logic adc_clk_en,
   output logic adc_comp_en,
   output logic adc_scan_mode,
   output logic adc_one_shot,
   output logic adc_hw_trigger,
   output logic [1:0] adc_channel,
   output logic [15:0] adc_conv_cycles,
   output logic adc_start,
   output logic adc_end_clr,
   output logic irq_enable,
   output logic [2:0] led_n,
   output logic [15:0] pwm_period_reg,
   output logic [15:0] led1_compare_reg,
   output logic [15:0] led2_compare_reg,
   output logic [15:0] led3_compare_reg,
   output logic pwm_running,
   output logic halted
);
   typedef struct packed {
      lbe_pkg::lbe_state_t st;
      logic [31:0] wait_cnt;
      logic [1:0] idx;
      logic [15:0] ref_v;
      logic [9:0] res0;
      logic [9:0] res1;
      logic [9:0] res2;
      logic [15:0] cmp0;
      logic [15:0] cmp1;
      logic [15:0] cmp2;
      logic [15:0] period;
      logic [15:0] pwm_cmp1;
      logic [15:0] pwm_cmp2;
      logic [15:0] pwm_cmp3;
      logic clk_en;
      logic comp_en;
      logic [1:0] chan;
      logic start;
      logic end_clr;
      logic irq_en;
      logic [2:0] led_drv_n;
      logic run;
      logic div_go;
      logic halt;
   } lbe_top_t;
   lbe_top_t r_q, r_d;
   logic div_busy;
   logic [31:0] div_quo;
   logic [31:0] div_num;
   logic [31:0] div_den;
   logic [2:0] pwm_n;
   logic [10:0] vres;
   logic [15:0] duty_val;
   if (PWM_PERIOD == 16'h0000)
   begin
      $error("period must be nonzero");
   end
   if (SUPPLY_WAIT < 1)
   begin
      $error("supply wait must be at least one cycle");
   end

   function automatic logic [9:0] pick_res(input lbe_top_t s, input logic [1:0] i);
      pick_res = (i == 2'h0) ? s.res0 : ((i == 2'h1) ? s.res1 : s.res2);
   endfunction

   // Resistor voltage is full scale minus the stored result.
   assign vres = lbe_pkg::FULL_SCALE - {1'b0, pick_res(r_q, r_q.idx)};
   // Reference uses the divider as well, so a single divider serves both sums.
   assign div_num = (r_q.st == lbe_pkg::LBE_REF)
      ? 32'(lbe_pkg::FULL_SCALE) * 32'(lbe_pkg::MAX_FORWARD_VOLTAGE_CONST)
      : 32'(r_q.period) * 32'(r_q.ref_v);
   assign div_den = (r_q.st == lbe_pkg::LBE_REF) ? 32'(lbe_pkg::VDD_MV) : 32'(vres);
   // A quotient above the period is clipped so the compare never passes it.
   assign duty_val = (div_quo > 32'(r_q.period)) ? r_q.period : div_quo[15:0];

   lbe_divider #(.WIDTH(32)) u_div (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .start(r_q.div_go),
      .dividend(div_num),
      .divisor(div_den),
      .busy(div_busy),
      .quotient(div_quo)
   );

   lbe_pwm #(.SLAVES(3)) u_pwm (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .run(r_q.run),
      .period(r_q.period),
      .compare({r_q.pwm_cmp3, r_q.pwm_cmp2, r_q.pwm_cmp1}),
      .pwm_n(pwm_n),
      .master_wrap()
   );

   always_comb
   begin
      r_d = r_q;
      r_d.start = 1'b0;
      r_d.end_clr = 1'b0;
      r_d.div_go = 1'b0;
      if (r_q.run)
         r_d.led_drv_n = pwm_n;
      case (r_q.st)
         lbe_pkg::LBE_RESET:
         begin
            r_d.chan = lbe_pkg::FIRST_CHANNEL;
            r_d.irq_en = 1'b0;
            r_d.wait_cnt = '0;
            r_d.st = lbe_pkg::LBE_SETTLE;
         end
         lbe_pkg::LBE_SETTLE:
         begin
            r_d.wait_cnt = r_q.wait_cnt + 32'h1;
            if (r_q.wait_cnt >= 32'(SUPPLY_WAIT - 1))
            begin
               r_d.div_go = 1'b1;
               r_d.st = lbe_pkg::LBE_REF;
            end
         end
         lbe_pkg::LBE_REF:
            r_d.st = lbe_pkg::LBE_REF_WAIT;
         lbe_pkg::LBE_REF_WAIT:
         begin
            if (!div_busy)
            begin
               r_d.ref_v = 16'(lbe_pkg::FULL_SCALE) - div_quo[15:0];
               r_d.period = PWM_PERIOD;
               r_d.led_drv_n = 3'h0;
               r_d.clk_en = 1'b1;
               r_d.comp_en = 1'b1;
               r_d.wait_cnt = '0;
               r_d.st = lbe_pkg::LBE_ADC_ON;
            end
         end
         lbe_pkg::LBE_ADC_ON:
         begin
            r_d.wait_cnt = r_q.wait_cnt + 32'h1;
            if (r_q.wait_cnt >= 32'(lbe_pkg::ADC_WAIT_CYCLES - 1))
            begin
               r_d.idx = 2'h0;
               r_d.st = lbe_pkg::LBE_CONV_START;
            end
         end
         lbe_pkg::LBE_CONV_START:
         begin
            r_d.chan = r_q.idx;
            r_d.start = 1'b1;
            r_d.st = lbe_pkg::LBE_CONV_WAIT;
         end
         lbe_pkg::LBE_CONV_WAIT:
         begin
            if (adc_end)
            begin
               r_d.end_clr = 1'b1;
               r_d.st = lbe_pkg::LBE_STORE;
            end
         end
         lbe_pkg::LBE_STORE:
         begin
            // Stored in the same cycle as the flag clear; the model keeps the result two cycles longer.
            if (r_q.idx == 2'h0) r_d.res0 = adc_result;
            if (r_q.idx == 2'h1) r_d.res1 = adc_result;
            if (r_q.idx == 2'h2) r_d.res2 = adc_result;
            if (r_q.idx == 2'(lbe_pkg::NUM_LEDS - 1))
               r_d.st = lbe_pkg::LBE_MEAS_DONE;
            else
            begin
               r_d.idx = r_q.idx + 2'h1;
               r_d.st = lbe_pkg::LBE_CONV_START;
            end
         end
         lbe_pkg::LBE_MEAS_DONE:
         begin
            r_d.led_drv_n = 3'h7;
            r_d.clk_en = 1'b0;
            r_d.comp_en = 1'b0;
            r_d.idx = 2'h0;
            r_d.st = lbe_pkg::LBE_DUTY;
         end
         lbe_pkg::LBE_DUTY:
         begin
            if (vres < 11'(r_q.ref_v))
            begin
               // Full duty: the compare equals the period.
               if (r_q.idx == 2'h0) r_d.cmp0 = r_q.period;
               if (r_q.idx == 2'h1) r_d.cmp1 = r_q.period;
               if (r_q.idx == 2'h2) r_d.cmp2 = r_q.period;
               r_d.st = lbe_pkg::LBE_DUTY_WAIT;
            end
            else
            begin
               r_d.div_go = 1'b1;
               r_d.st = lbe_pkg::LBE_DUTY_WAIT;
            end
         end
         lbe_pkg::LBE_DUTY_WAIT:
         begin
            if (!div_busy && !r_q.div_go)
            begin
               if (vres >= 11'(r_q.ref_v))
               begin
                  if (r_q.idx == 2'h0) r_d.cmp0 = duty_val;
                  if (r_q.idx == 2'h1) r_d.cmp1 = duty_val;
                  if (r_q.idx == 2'h2) r_d.cmp2 = duty_val;
               end
               if (r_q.idx == 2'(lbe_pkg::NUM_LEDS - 1))
                  r_d.st = lbe_pkg::LBE_LOAD;
               else
               begin
                  r_d.idx = r_q.idx + 2'h1;
                  r_d.st = lbe_pkg::LBE_DUTY;
               end
            end
         end
         lbe_pkg::LBE_LOAD:
         begin
            r_d.pwm_cmp1 = r_q.cmp0;
            r_d.pwm_cmp2 = r_q.cmp1;
            r_d.pwm_cmp3 = r_q.cmp2;
            r_d.led_drv_n = 3'h0;
            r_d.run = 1'b1;
            r_d.st = lbe_pkg::LBE_HALT;
         end
         lbe_pkg::LBE_HALT:
            r_d.st = lbe_pkg::LBE_HALT;
         default:
            r_d.st = lbe_pkg::LBE_HALT;
      endcase
      r_d.halt = (r_d.st == lbe_pkg::LBE_HALT);
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         r_q <= '0;
         r_q.st <= lbe_pkg::LBE_RESET;
         r_q.led_drv_n <= 3'h7;
      end
      else
         r_q <= r_d;
   end

   assign adc_clk_en = r_q.clk_en;
   assign adc_comp_en = r_q.comp_en;
   assign adc_scan_mode = 1'b0;
   assign adc_one_shot = 1'b1;
   assign adc_hw_trigger = 1'b0;
   assign adc_conv_cycles = 16'(lbe_pkg::CONV_CYCLES);
   assign adc_channel = r_q.chan;
   assign adc_start = r_q.start;
   assign adc_end_clr = r_q.end_clr;
   assign irq_enable = r_q.irq_en;
   assign led_n = r_q.led_drv_n;
   assign pwm_period_reg = r_q.period;
   assign led1_compare_reg = r_q.pwm_cmp1;
   assign led2_compare_reg = r_q.pwm_cmp2;
   assign led3_compare_reg = r_q.pwm_cmp3;
   assign pwm_running = r_q.run;
   assign halted = r_q.halt;

   // Conversion steps: start, end seen after the wait, flag cleared next cycle, result stored in that same cycle.
   property start_then_wait;
      @(posedge core_clk) disable iff (!arst_n)
      adc_start |-> r_q.st == lbe_pkg::LBE_CONV_WAIT;
   endproperty
   sequence start_pulse;
      adc_start && adc_channel == r_q.idx ##1 !adc_start;
   endsequence
   property start_issued;
      @(posedge core_clk) disable iff (!arst_n)
      r_q.st == lbe_pkg::LBE_CONV_START |=> start_pulse;
   endproperty
   property measure_setup;
      @(posedge core_clk) disable iff (!arst_n)
      adc_start |-> adc_comp_en && adc_clk_en && led_n == 3'h0;
   endproperty
   sequence end_seen;
      r_q.st == lbe_pkg::LBE_CONV_WAIT && adc_end;
   endsequence
   sequence clear_pulse;
      adc_end_clr && r_q.st == lbe_pkg::LBE_STORE ##1 !adc_end_clr;
   endsequence
   property end_then_clear;
      @(posedge core_clk) disable iff (!arst_n)
      end_seen |=> clear_pulse;
   endproperty
   property clear_then_store;
      @(posedge core_clk) disable iff (!arst_n)
      adc_end_clr |=> r_q.st == lbe_pkg::LBE_MEAS_DONE || r_q.st == lbe_pkg::LBE_CONV_START;
   endproperty
   property irq_never;
      @(posedge core_clk) disable iff (!arst_n)
      !irq_enable;
   endproperty
   property ref_ready;
      @(posedge core_clk) disable iff (!arst_n)
      r_q.st == lbe_pkg::LBE_ADC_ON |-> r_q.ref_v == 16'h0200;
   endproperty
   property adc_stopped;
      @(posedge core_clk) disable iff (!arst_n)
      r_q.st == lbe_pkg::LBE_DUTY |-> !adc_clk_en && led_n == 3'h7;
   endproperty
   property cmp_in_range;
      @(posedge core_clk) disable iff (!arst_n)
      pwm_running |-> led1_compare_reg <= pwm_period_reg && led2_compare_reg <= pwm_period_reg
         && led3_compare_reg <= pwm_period_reg;
   endproperty
   property halt_holds;
      @(posedge core_clk) disable iff (!arst_n)
      halted |=> halted && pwm_running;
   endproperty
   property load_then_run;
      @(posedge core_clk) disable iff (!arst_n)
      $rose(pwm_running) |-> halted && led_n == 3'h0;
   endproperty
   // The pins lag the counter by one register stage, which keeps the led_n pins a flop.
   property led_follows_pwm;
      @(posedge core_clk) disable iff (!arst_n)
      pwm_running |=> led_n == $past(pwm_n);
   endproperty
   conv_start_a: assert property (start_then_wait) else $error("start without wait");
   conv_pulse_a: assert property (start_issued) else $error("bad start pulse");
   meas_setup_a: assert property (measure_setup) else $error("measure setup wrong");
   end_ack_a: assert property (end_then_clear) else $error("end not cleared");
   end_clear_a: assert property (clear_then_store) else $error("no store after clear");
   irq_off_a: assert property (irq_never) else $error("interrupts enabled");
   ref_value_a: assert property (ref_ready) else $error("reference not 512");
   adc_off_a: assert property (adc_stopped) else $error("converter left on");
   cmp_sat_a: assert property (cmp_in_range) else $error("compare above period");
   halt_stays_a: assert property (halt_holds) else $error("left halt");
   load_run_a: assert property (load_then_run) else $error("pwm start wrong");
   led_pwm_a: assert property (led_follows_pwm) else $error("led not following pwm");
endmodule
`default_nettype wire

// ==== verilog/lbe_pkg.sv ====
`default_nettype none
package lbe_pkg;
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned CONV_TIME_NS = 19000;
   localparam int unsigned CONV_CYCLES = CONV_TIME_NS * CLK_MHZ / 1000;
   localparam int unsigned SUPPLY_WAIT_US = 100;
   localparam int unsigned SUPPLY_WAIT_CYCLES = SUPPLY_WAIT_US * CLK_MHZ;
   localparam int unsigned ADC_WAIT_US = 1;
   localparam int unsigned ADC_WAIT_CYCLES = ADC_WAIT_US * CLK_MHZ;
   localparam int unsigned MAX_FORWARD_VOLTAGE_CONST = 2500;
   localparam int unsigned VDD_MV = 5000;
   localparam logic [10:0] FULL_SCALE = 11'h400;
   localparam logic [15:0] PERIOD_RESET = 16'h03e8;
   localparam int unsigned NUM_LEDS = 3;
   localparam logic [1:0] FIRST_CHANNEL = 2'h0;
   typedef enum logic [3:0] {
      LBE_RESET, LBE_SETTLE, LBE_REF, LBE_REF_WAIT, LBE_ADC_ON, LBE_ADC_WAIT,
      LBE_CONV_START, LBE_CONV_WAIT, LBE_STORE, LBE_MEAS_DONE, LBE_DUTY,
      LBE_DUTY_WAIT, LBE_LOAD, LBE_HALT
   } lbe_state_t;
endpackage
`default_nettype wire

// ==== verilog/lbe_divider.sv ====
`timescale 1ns/10ps
`default_nettype none
// Restoring divider, one quotient bit per clock; start is ignored while busy.
module lbe_divider #(
   parameter int unsigned WIDTH = 32
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic start,
   input wire logic [WIDTH-1:0] dividend,
   input wire logic [WIDTH-1:0] divisor,
   output logic busy,
   output logic [WIDTH-1:0] quotient
);
   typedef struct packed {
      logic busy;
      logic [$clog2(WIDTH+1)-1:0] cnt;
      logic [WIDTH-1:0] rem;
      logic [WIDTH-1:0] quo;
      logic [WIDTH-1:0] dsr;
   } lbe_div_t;
   lbe_div_t r_q, r_d;
   logic [WIDTH:0] trial;
   // Refused at elaboration: the shift step needs at least two quotient bits.
   if (WIDTH < 2)
   begin
      $error("divider width too small");
   end
   always_comb
   begin
      r_d = r_q;
      trial = '0;
      if (!r_q.busy && start)
      begin
         r_d.busy = 1'b1;
         r_d.cnt = '0;
         r_d.rem = '0;
         r_d.quo = dividend;
         r_d.dsr = divisor;
      end
      else if (r_q.busy)
      begin
         trial = {r_q.rem, r_q.quo[WIDTH-1]} - {1'b0, r_q.dsr};
         if (!trial[WIDTH])
         begin
            r_d.rem = trial[WIDTH-1:0];
            r_d.quo = {r_q.quo[WIDTH-2:0], 1'b1};
         end
         else
         begin
            r_d.rem = {r_q.rem[WIDTH-2:0], r_q.quo[WIDTH-1]};
            r_d.quo = {r_q.quo[WIDTH-2:0], 1'b0};
         end
         r_d.cnt = r_q.cnt + 1'b1;
         if (r_q.cnt == ($clog2(WIDTH+1))'(WIDTH - 1))
            r_d.busy = 1'b0;
      end
   end
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         r_q <= '0;
      else
         r_q <= r_d;
   end
   assign busy = r_q.busy;
   assign quotient = r_q.quo;
endmodule
`default_nettype wire

// ==== verilog/lbe_pwm.sv ====
`timescale 1ns/10ps
`default_nettype none
// Period master counter with slave compare outputs, active low.
module lbe_pwm #(
   parameter int unsigned SLAVES = 3
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic run,
   input wire logic [15:0] period,
   input wire logic [SLAVES*16-1:0] compare,
   output logic [SLAVES-1:0] pwm_n,
   output logic master_wrap
);
   typedef struct packed {
      logic [15:0] cnt;
      logic [SLAVES-1:0] out_n;
      logic wrap;
   } lbe_pwm_t;
   lbe_pwm_t r_q, r_d;
   if (SLAVES < 1)
   begin
      $error("need at least one slave channel");
   end
   always_comb
   begin
      r_d = r_q;
      r_d.wrap = 1'b0;
      if (run)
      begin
         // Master channel has no pin; its wrap is kept internal.
         if (r_q.cnt >= period - 16'h0001)
         begin
            r_d.cnt = 16'h0000;
            r_d.wrap = 1'b1;
         end
         else
            r_d.cnt = r_q.cnt + 16'h0001;
         for (int i = 0; i < SLAVES; i++)
            r_d.out_n[i] = !(r_d.cnt < compare[i*16 +: 16]);
      end
      else
         r_d.out_n = '0;
   end
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         r_q <= '0;
      else
         r_q <= r_d;
   end
   assign pwm_n = r_q.out_n;
   assign master_wrap = r_q.wrap;
endmodule
`default_nettype wire

// ==== tb/lbe_led_adc_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Three LEDs sensed by a one-shot converter. A start with the converter clock on yields
// one result after the given delay; the end flag stays up until it is cleared.
module lbe_led_adc_model (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic adc_start,
   input wire logic adc_clk_en,
   input wire logic [1:0] adc_channel,
   input wire logic adc_end_clr,
   input wire logic [15:0] delay,
   input wire logic [29:0] levels,
   output logic adc_end,
   output logic [9:0] adc_result
);
   int cnt;
   int hold;
   logic [1:0] ch;
   always_ff @(posedge core_clk or negedge arst_n)
      if (!arst_n)
      begin
         cnt <= 0;
         hold <= 0;
         ch <= 2'h0;
         adc_end <= 1'b0;
         adc_result <= 10'h2aa;
      end
      else
      begin
         if (adc_start && adc_clk_en)
         begin
            ch <= adc_channel;
            cnt <= int'(delay);
         end
         else if (cnt > 0)
            cnt <= cnt - 1;
         if (cnt == 1)
         begin
            adc_end <= 1'b1;
            adc_result <= levels[ch*10 +: 10];
         end
         if (adc_end_clr)
         begin
            adc_end <= 1'b0;
            hold <= 2;
         end
         else if (hold > 0)
            hold <= hold - 1;
         // Once the result has been taken the line no longer shows it.
         if (hold == 1)
            adc_result <= ~adc_result;
      end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam logic [15:0] PER = 16'h0064;
   logic core_clk;
   logic arst_n;
   logic slow;
   logic [9:0] res [3];
   logic adc_end, adc_clk_en, adc_comp_en, adc_scan_mode, adc_one_shot, adc_hw_trigger;
   logic adc_start, adc_end_clr, irq_enable, pwm_running, halted;
   logic [9:0] adc_result;
   logic [1:0] adc_channel;
   logic [2:0] led_n;
   logic [15:0] adc_conv_cycles, pwm_period_reg, led1_compare_reg, led2_compare_reg;
   logic [15:0] led3_compare_reg;
   int err_total = 0;
   int checked = 0;
   int seed = 41778;
   int st_idx;
   int clr_cnt;
   time t_rel;
   time t_first;

   lbe_top #(.SUPPLY_WAIT(10), .PWM_PERIOD(PER)) lbe_top_i (.core_clk(core_clk),
      .arst_n(arst_n), .adc_end(adc_end), .adc_result(adc_result),
      .adc_clk_en(adc_clk_en), .adc_comp_en(adc_comp_en), .adc_scan_mode(adc_scan_mode),
      .adc_one_shot(adc_one_shot), .adc_hw_trigger(adc_hw_trigger),
      .adc_channel(adc_channel), .adc_conv_cycles(adc_conv_cycles), .adc_start(adc_start),
      .adc_end_clr(adc_end_clr), .irq_enable(irq_enable), .led_n(led_n),
      .pwm_period_reg(pwm_period_reg), .led1_compare_reg(led1_compare_reg),
      .led2_compare_reg(led2_compare_reg), .led3_compare_reg(led3_compare_reg),
      .pwm_running(pwm_running), .halted(halted));

   lbe_led_adc_model lbe_led_adc_model_i (.core_clk(core_clk), .arst_n(arst_n),
      .adc_start(adc_start), .adc_clk_en(adc_clk_en), .adc_channel(adc_channel),
      .adc_end_clr(adc_end_clr), .delay(slow ? adc_conv_cycles : 16'h0004),
      .levels({res[2], res[1], res[0]}), .adc_end(adc_end), .adc_result(adc_result));

   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_cnt(input int got, input int exp);
      checked++;
      if (got != exp)
      begin
         err_total++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Expected compare value worked out from the measured level.
   function automatic logic [15:0] exp_cmp(input int r);
      int rf;
      int v;
      rf = 1024 - 1024 * lbe_pkg::MAX_FORWARD_VOLTAGE_CONST / lbe_pkg::VDD_MV;
      v = 1024 - r;
      if (v <= rf)
         return PER;
      return 16'(int'(PER) * rf / v);
   endfunction

   always @(posedge core_clk)
      if (arst_n === 1'b1 && adc_start === 1'b1)
      begin
         chk16(16'(adc_channel), 16'(st_idx));
         chk16({13'h0, adc_comp_en, adc_clk_en, irq_enable}, 16'h0006);
         chk16({13'h0, led_n}, 16'h0000);
         if (st_idx == 0)
            t_first = $time;
         st_idx++;
      end

   always @(posedge core_clk)
      if (arst_n === 1'b1 && adc_end_clr === 1'b1)
      begin
         chk16({15'h0, adc_end}, 16'h0001);
         clr_cnt++;
      end

   task automatic run_case(input int r0, input int r1, input int r2, input logic sl,
      input bit abort);
      int n;
      int lo [3];
      logic [15:0] cmp [3];
      res[0] = 10'(r0);
      res[1] = 10'(r1);
      res[2] = 10'(r2);
      slow = sl;
      arst_n = 1'b0;
      st_idx = 0;
      clr_cnt = 0;
      repeat (5) @(posedge core_clk);
      #1 arst_n = 1'b1;
      t_rel = $time;
      chk16({13'h0, led_n}, 16'h0007);
      chk16({13'h0, adc_scan_mode, adc_one_shot, adc_hw_trigger}, 16'h0002);
      chk16(adc_conv_cycles, 16'(lbe_pkg::CONV_CYCLES));
      n = 0;
      while (halted !== 1'b1 && n < 20000 && !(abort && st_idx == 2))
      begin
         @(posedge core_clk);
         #1 n++;
         chk16({15'h0, irq_enable}, 16'h0000);
      end
      if (abort)
         return;
      chk_cnt(n < 20000, 1);
      chk_cnt((t_first - t_rel) / 5 >= 10 + lbe_pkg::ADC_WAIT_CYCLES, 1);
      chk_cnt(clr_cnt, 3);
      chk16({14'h0, adc_clk_en, pwm_running}, 16'h0001);
      chk16(pwm_period_reg, PER);
      cmp[0] = exp_cmp(r0);
      cmp[1] = exp_cmp(r1);
      cmp[2] = exp_cmp(r2);
      chk16(led1_compare_reg, cmp[0]);
      chk16(led2_compare_reg, cmp[1]);
      chk16(led3_compare_reg, cmp[2]);
      repeat (3) @(posedge core_clk);
      lo = '{0, 0, 0};
      repeat (2 * int'(PER))
      begin
         @(posedge core_clk);
         #1;
         for (int i = 0; i < 3; i++)
            lo[i] += (led_n[i] === 1'b0);
      end
      for (int i = 0; i < 3; i++)
         chk_cnt(lo[i], 2 * int'(cmp[i]));
      chk_cnt(st_idx, 3);
      chk16({15'h0, halted}, 16'h0001);
   endtask

   initial
   begin
      arst_n = 1'b0;
      slow = 1'b0;
      res = '{10'h0, 10'h0, 10'h0};
      run_case(0, 511, 512, 1'b0, 0);
      run_case(513, 1023, 700, 1'b1, 0);
      run_case(300, 900, 100, 1'b0, 1);
      for (int k = 0; k < 4; k++)
         run_case($unsigned($random(seed)) % 1024, $unsigned($random(seed)) % 1024,
            $unsigned($random(seed)) % 1024, k[0], 0);
      results();
   end

   // Three slow runs of about 12000 cycles bound the run well below this span.
   initial
   begin
      repeat (95000) @(posedge core_clk);
      err_total++;
      results();
   end
endmodule
`default_nettype wire
